// File: rtl/nmf_pkg.sv
package nmf_pkg;

    // Manager command codes
    localparam logic [15:0] CMD_LOCK_REQ   = 16'h8500;
    localparam logic [15:0] CMD_LOCK_QUERY = 16'h8501;
    localparam logic [15:0] CMD_LOCK_FREE  = 16'h8502;
    localparam logic [15:0] CMD_MGR_CFG    = 16'h8503;
    localparam logic [15:0] CMD_READ       = 16'h8504;
    localparam logic [15:0] CMD_WRITE      = 16'h8505;
    localparam logic [15:0] CMD_ERASE_BLK  = 16'h8506;
    localparam logic [15:0] CMD_ERASE_ALL  = 16'h8507;
    localparam logic [15:0] CMD_QUERY_DEV  = 16'h8508;
    localparam logic [15:0] CMD_OP_POLL    = 16'h8509;
    localparam logic [15:0] CMD_DEV_CFG    = 16'h850A;
    localparam logic [15:0] CMD_VALIDATE   = 16'h850D;
    localparam logic [15:0] CMD_VAL_POLL   = 16'h850E;
    localparam logic [15:0] CMD_ISSUE_OP   = 16'h850F;
    localparam logic [15:0] CMD_ISSUE_RSP  = 16'h8510;

    // Result codes
    localparam logic [3:0] RES_OK        = 4'h0;
    localparam logic [3:0] RES_PENDING   = 4'h1;
    localparam logic [3:0] RES_ALREADY   = 4'h2;
    localparam logic [3:0] RES_NOT_OWNER = 4'h3;
    localparam logic [3:0] RES_INVALID   = 4'h4;
    localparam logic [3:0] RES_UNKNOWN   = 4'h5;

    // Register offsets
    localparam logic [7:0] REG_CMD       = 8'h00;
    localparam logic [7:0] REG_RESULT    = 8'h04;
    localparam logic [7:0] REG_STATUS    = 8'h08;
    localparam logic [7:0] REG_MCFG_RATE = 8'h0C;
    localparam logic [7:0] REG_MCFG_MODE = 8'h10;
    localparam logic [7:0] REG_DCFG_LO   = 8'h14;
    localparam logic [7:0] REG_DCFG_SIZE = 8'h18;

    // Field positions
    localparam int RESULT_ASYNC_BIT = 8;
    localparam int STAT_OWNER_BIT   = 0;
    localparam int STAT_LPEND_BIT   = 1;
    localparam int STAT_OPBUSY_BIT  = 2;

    // Record field encodings and limits
    localparam logic [7:0]  PHASE_MODE_0  = 8'h00;
    localparam logic [7:0]  PHASE_MODE_3  = 8'h03;
    localparam logic [7:0]  RSEL_STD      = 8'h00;
    localparam logic [7:0]  RSEL_FAST     = 8'h01;
    localparam logic [7:0]  OPC_READ_STD  = 8'h03;
    localparam logic [7:0]  OPC_READ_FAST = 8'h0B;
    localparam logic [7:0]  DRV_READONLY  = 8'h00;
    localparam logic [7:0]  DRV_FLASH_RW  = 8'h01;
    localparam logic [7:0]  DRV_EEPROM_RW = 8'h02;
    localparam logic [31:0] RATE_FLOOR    = 32'h000F_4240;
    localparam logic [31:0] RATE_CEILING  = 32'h02FA_F080;

    typedef struct packed {
        logic [31:0] serial_clock_rate;
        logic [7:0]  serial_clock_phase_mode;
        logic [7:0]  read_opcode_select;
    } nmf_mgr_cfg_t;

    typedef struct packed {
        logic [7:0]  nvm_driver_select;
        logic [7:0]  device_read_opcode;
        logic [7:0]  address_byte_count;
        logic [7:0]  reserved;
        logic [31:0] capacity;
    } nmf_dev_cfg_t;

    localparam nmf_mgr_cfg_t MGR_CFG_RST = '{RATE_FLOOR, PHASE_MODE_0,
                                             RSEL_STD};
    localparam nmf_dev_cfg_t DEV_CFG_RST = '{DRV_READONLY, RSEL_STD,
                                             8'h00, 8'h00, 32'h0000_0000};

    function automatic logic cmd_is_async(input logic [15:0] code);
        return code == CMD_LOCK_REQ || code == CMD_READ ||
               code == CMD_WRITE || code == CMD_ERASE_BLK ||
               code == CMD_ERASE_ALL || code == CMD_QUERY_DEV ||
               code == CMD_VALIDATE || code == CMD_ISSUE_OP;
    endfunction

    function automatic logic mgr_cfg_ok(input nmf_mgr_cfg_t c);
        return c.serial_clock_rate >= RATE_FLOOR &&
               c.serial_clock_rate <= RATE_CEILING &&
               (c.serial_clock_phase_mode == PHASE_MODE_0 ||
                c.serial_clock_phase_mode == PHASE_MODE_3) &&
               (c.read_opcode_select == RSEL_STD ||
                c.read_opcode_select == RSEL_FAST);
    endfunction

    function automatic logic dev_cfg_ok(input nmf_dev_cfg_t c);
        return c.nvm_driver_select <= DRV_EEPROM_RW &&
               (c.device_read_opcode == RSEL_STD ||
                c.device_read_opcode == RSEL_FAST);
    endfunction

endpackage

// File: rtl/nmf_lock_arb.sv
`timescale 1ns/10ps
module nmf_lock_arb
    import nmf_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Lock requests
    input  wire logic req,
    input  wire logic free,
    input  wire logic shared_busy,
    // Lock state
    output logic      owner,
    output logic      pending
);

    typedef enum logic [2:0] {
        ST_FREE = 3'b001,
        ST_WAIT = 3'b010,
        ST_OWN  = 3'b100
    } nmf_lock_st_t;

    typedef struct packed {
        nmf_lock_st_t st;
    } nmf_lock_t;

    nmf_lock_t s;
    nmf_lock_t next_s;

    always_comb begin
        next_s = s;
        unique case (s.st)
            ST_FREE: begin
                if (req) begin
                    next_s.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!shared_busy) begin
                    next_s.st = ST_OWN;
                end
            end
            ST_OWN: begin
                if (free) begin
                    next_s.st = ST_FREE;
                end
            end
            default: begin
                next_s.st = ST_FREE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s.st <= ST_FREE;
        end else begin
            s <= next_s;
        end
    end

    // One-hot state bits drive the flags straight from the flip-flops
    assign owner   = s.st[2];
    assign pending = s.st[1];

endmodule

// File: rtl/nmf_cfg_hold.sv
`timescale 1ns/10ps
module nmf_cfg_hold
    import nmf_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Apply strobes and staged records
    input  wire logic         apply_mgr,
    input  wire logic         apply_dev,
    input  wire nmf_mgr_cfg_t mgr_in,
    input  wire nmf_dev_cfg_t dev_in,
    // Active records
    output nmf_mgr_cfg_t      mgr_out,
    output nmf_dev_cfg_t      dev_out,
    output logic [7:0]        read_opcode
);

    typedef struct packed {
        nmf_mgr_cfg_t mgr;
        nmf_dev_cfg_t dev;
        logic [7:0]   opc;
    } nmf_hold_t;

    nmf_hold_t s;
    nmf_hold_t next_s;

    always_comb begin
        next_s = s;
        if (apply_mgr) begin
            next_s.mgr = mgr_in;
            next_s.opc = (mgr_in.read_opcode_select == RSEL_FAST) ?
                         OPC_READ_FAST : OPC_READ_STD;
        end
        if (apply_dev) begin
            next_s.dev          = dev_in;
            next_s.dev.reserved = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s.mgr <= MGR_CFG_RST;
            s.dev <= DEV_CFG_RST;
            s.opc <= OPC_READ_STD;
        end else begin
            s <= next_s;
        end
    end

    assign mgr_out     = s.mgr;
    assign dev_out     = s.dev;
    assign read_opcode = s.opc;

endmodule

// File: rtl/nmf_cmd_front.sv
//Behaviour
// - 0x8500 asynchronously requests the access lock
// - Lock request answers ok, pending or already held
// - 0x8501 reports ok once held, pending while requested, else not-owner
// - 0x8502 synchronously frees the access lock
// - 0x8503 synchronously applies manager configuration
// - 0x8504 async read, 0x8505 async write
// - 0x8506 block erase, 0x8507 device erase
// - 0x8508 async query, 0x8509 operation poll
// - 0x850A synchronously configures memory device
// - 0x850D async validation, 0x850E its poll
// - 0x850F issues opcode, 0x8510 fetches reply
// - 48-bit manager record, rate bounds, mode 0/3
// - Read select picks opcode 0x03 or 0x0B
// - Driver select: readonly, flash, eeprom
// - Device record: opcode, address bytes, reserved, capacity
// - Unowned lock-needing commands get not-owner
// - Free answers ok, or pending if requesting
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module nmf_cmd_front
    import nmf_pkg::*;
(
    // Clock and reset
    input  wire logic         CORE_CLK,
    input  wire logic         RST_B,
    // Register port
    input  wire logic [7:0]   ADDR,
    input  wire logic [31:0]  WR_DATA,
    input  wire logic         WR_EN,
    input  wire logic         RD_EN,
    output logic [31:0]       RD_DATA,
    // Memory engine side
    input  wire logic         SHARED_BUSY,
    input  wire logic         OP_DONE,
    output logic              OP_START,
    output logic [15:0]       OP_CMD,
    // Lock and active configuration
    output logic              LOCK_HELD,
    output nmf_mgr_cfg_t      MGR_CFG,
    output nmf_dev_cfg_t      DEV_CFG,
    output logic [7:0]        READ_OPCODE
);

    typedef struct packed {
        logic [15:0]  cmd;
        logic [3:0]   result;
        logic         async;
        logic         op_busy;
        logic         op_val;
        logic         op_start;
        logic [15:0]  op_cmd;
        nmf_mgr_cfg_t mcfg;
        nmf_dev_cfg_t dcfg;
        logic [31:0]  rd_data;
    } nmf_front_t;

    nmf_front_t  s;
    nmf_front_t  next_s;
    logic        owner;
    logic        lock_pend;
    logic        lock_req;
    logic        lock_free;
    logic        apply_mgr;
    logic        apply_dev;
    logic        wr_cmd;
    logic [15:0] code;

    assign wr_cmd = WR_EN && ADDR == REG_CMD;
    assign code   = WR_DATA[15:0];

    // Lock owner and request tracking
    nmf_lock_arb u_lock (
        .clk         (CORE_CLK),
        .rst_b       (RST_B),
        .req         (lock_req),
        .free        (lock_free),
        .shared_busy (SHARED_BUSY),
        .owner       (owner),
        .pending     (lock_pend)
    );

    // Active configuration records
    nmf_cfg_hold u_cfg (
        .clk         (CORE_CLK),
        .rst_b       (RST_B),
        .apply_mgr   (apply_mgr),
        .apply_dev   (apply_dev),
        .mgr_in      (s.mcfg),
        .dev_in      (s.dcfg),
        .mgr_out     (MGR_CFG),
        .dev_out     (DEV_CFG),
        .read_opcode (READ_OPCODE)
    );

    always_comb begin
        next_s          = s;
        next_s.op_start = 1'b0;
        next_s.rd_data  = 32'h0000_0000;
        lock_req        = 1'b0;
        lock_free       = 1'b0;
        apply_mgr       = 1'b0;
        apply_dev       = 1'b0;
        // Operation completion; a start in the same cycle wins
        if (OP_DONE) begin
            next_s.op_busy = 1'b0;
        end
        if (WR_EN) begin
            case (ADDR)
                REG_MCFG_RATE: begin
                    next_s.mcfg.serial_clock_rate = WR_DATA;
                end
                REG_MCFG_MODE: begin
                    next_s.mcfg.serial_clock_phase_mode = WR_DATA[7:0];
                    next_s.mcfg.read_opcode_select      = WR_DATA[15:8];
                end
                REG_DCFG_LO: begin
                    next_s.dcfg.nvm_driver_select  = WR_DATA[7:0];
                    next_s.dcfg.device_read_opcode = WR_DATA[15:8];
                    next_s.dcfg.address_byte_count = WR_DATA[23:16];
                    next_s.dcfg.reserved           = WR_DATA[31:24];
                end
                REG_DCFG_SIZE: begin
                    next_s.dcfg.capacity = WR_DATA;
                end
                default: begin
                end
            endcase
        end
        if (wr_cmd) begin
            next_s.cmd   = code;
            next_s.async = cmd_is_async(code);
            case (code)
                CMD_LOCK_REQ: begin
                    if (owner) begin
                        next_s.result = RES_ALREADY;
                    end else if (lock_pend) begin
                        next_s.result = RES_PENDING;
                    end else begin
                        next_s.result = RES_OK;
                        lock_req      = 1'b1;
                    end
                end
                CMD_LOCK_QUERY: begin
                    if (owner) begin
                        next_s.result = RES_OK;
                    end else if (lock_pend) begin
                        next_s.result = RES_PENDING;
                    end else begin
                        next_s.result = RES_NOT_OWNER;
                    end
                end
                CMD_LOCK_FREE: begin
                    if (lock_pend) begin
                        next_s.result = RES_PENDING;
                    end else begin
                        next_s.result = RES_OK;
                        lock_free     = 1'b1;
                    end
                end
                CMD_MGR_CFG, CMD_DEV_CFG, CMD_OP_POLL, CMD_VAL_POLL,
                CMD_ISSUE_RSP, CMD_READ, CMD_WRITE, CMD_ERASE_BLK,
                CMD_ERASE_ALL, CMD_QUERY_DEV, CMD_VALIDATE,
                CMD_ISSUE_OP: begin
                    if (!owner) begin
                        next_s.result = RES_NOT_OWNER;
                    end else if (code == CMD_MGR_CFG) begin
                        apply_mgr     = mgr_cfg_ok(s.mcfg);
                        next_s.result = apply_mgr ? RES_OK : RES_INVALID;
                    end else if (code == CMD_DEV_CFG) begin
                        apply_dev     = dev_cfg_ok(s.dcfg);
                        next_s.result = apply_dev ? RES_OK : RES_INVALID;
                    end else if (code == CMD_VAL_POLL) begin
                        next_s.result = (s.op_busy && s.op_val) ?
                                        RES_PENDING : RES_OK;
                    end else if (code == CMD_OP_POLL ||
                                 code == CMD_ISSUE_RSP) begin
                        next_s.result = s.op_busy ?
                                        RES_PENDING : RES_OK;
                    end else if (s.op_busy) begin
                        next_s.result = RES_PENDING;
                    end else begin
                        // Async read, write, erase, query, validate, issue
                        next_s.result   = RES_OK;
                        next_s.op_start = 1'b1;
                        next_s.op_cmd   = code;
                        next_s.op_busy  = 1'b1;
                        next_s.op_val   = code == CMD_VALIDATE;
                    end
                end
                default: begin
                    next_s.result = RES_UNKNOWN;
                end
            endcase
        end
        if (RD_EN) begin
            case (ADDR)
                REG_CMD: begin
                    next_s.rd_data[15:0] = s.cmd;
                end
                REG_RESULT: begin
                    next_s.rd_data[3:0]             = s.result;
                    next_s.rd_data[RESULT_ASYNC_BIT] = s.async;
                end
                REG_STATUS: begin
                    next_s.rd_data[STAT_OWNER_BIT]  = owner;
                    next_s.rd_data[STAT_LPEND_BIT]  = lock_pend;
                    next_s.rd_data[STAT_OPBUSY_BIT] = s.op_busy;
                end
                REG_MCFG_RATE: begin
                    next_s.rd_data = MGR_CFG.serial_clock_rate;
                end
                REG_MCFG_MODE: begin
                    next_s.rd_data[7:0]  = MGR_CFG.serial_clock_phase_mode;
                    next_s.rd_data[15:8] = MGR_CFG.read_opcode_select;
                end
                REG_DCFG_LO: begin
                    next_s.rd_data[7:0]   = DEV_CFG.nvm_driver_select;
                    next_s.rd_data[15:8]  = DEV_CFG.device_read_opcode;
                    next_s.rd_data[23:16] = DEV_CFG.address_byte_count;
                    next_s.rd_data[31:24] = DEV_CFG.reserved;
                end
                REG_DCFG_SIZE: begin
                    next_s.rd_data = DEV_CFG.capacity;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            s.cmd      <= 16'h0000;
            s.result   <= RES_OK;
            s.async    <= 1'b0;
            s.op_busy  <= 1'b0;
            s.op_val   <= 1'b0;
            s.op_start <= 1'b0;
            s.op_cmd   <= 16'h0000;
            s.mcfg     <= MGR_CFG_RST;
            s.dcfg     <= DEV_CFG_RST;
            s.rd_data  <= 32'h0000_0000;
        end else begin
            s <= next_s;
        end
    end

    assign RD_DATA   = s.rd_data;
    assign OP_START  = s.op_start;
    assign OP_CMD    = s.op_cmd;
    assign LOCK_HELD = owner;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);

    a_lock_request: assert property (
        wr_cmd && code == CMD_LOCK_REQ && !owner && !lock_pend
        |=> s.result == RES_OK && lock_pend && !owner)
        else $error("lock request not accepted");

    a_lock_already: assert property (
        wr_cmd && code == CMD_LOCK_REQ && owner
        |=> s.result == RES_ALREADY && LOCK_HELD)
        else $error("held lock not reported");

    a_lock_query: assert property (
        wr_cmd && code == CMD_LOCK_QUERY && lock_pend
        |=> s.result == (($past(owner)) ? RES_OK : RES_PENDING))
        else $error("lock query answer wrong");

    a_lock_free: assert property (
        wr_cmd && code == CMD_LOCK_FREE && !lock_pend
        |=> s.result == RES_OK && !LOCK_HELD ##1 !LOCK_HELD)
        else $error("lock free failed");

    a_not_owner: assert property (
        wr_cmd && code == CMD_READ && !owner
        |=> s.result == RES_NOT_OWNER && !OP_START)
        else $error("unowned command not refused");

    a_async_start: assert property (
        wr_cmd && code == CMD_WRITE && owner && !s.op_busy
        |=> OP_START && OP_CMD == CMD_WRITE ##1 !OP_START)
        else $error("async start pulse wrong");

    a_mgr_apply: assert property (
        wr_cmd && code == CMD_MGR_CFG && owner && mgr_cfg_ok(s.mcfg)
        |=> MGR_CFG == $past(s.mcfg) && READ_OPCODE ==
            ((MGR_CFG.read_opcode_select == RSEL_FAST) ?
             OPC_READ_FAST : OPC_READ_STD))
        else $error("manager record not applied");

    a_dev_reject: assert property (
        wr_cmd && code == CMD_DEV_CFG && owner &&
        s.dcfg.nvm_driver_select > DRV_EEPROM_RW
        |=> s.result == RES_INVALID && $stable(DEV_CFG))
        else $error("bad driver accepted");

    a_reset_clear: assert property (
        @(posedge CORE_CLK) disable iff (1'b0)
        !RST_B |=> !LOCK_HELD && !lock_pend && !OP_START)
        else $error("lock state not cleared");

    c_lock_grant: cover property (
        lock_pend ##1 owner);
    c_op_cycle: cover property (
        OP_START ##[1:20] OP_DONE);
    c_cfg_apply: cover property (
        apply_mgr ##[1:50] apply_dev);

endmodule

// File: sim/nmf_mem_model.sv
`timescale 1ns/10ps
module nmf_mem_model
(
    // Clock
    input  wire logic        clk,
    // Bench control
    input  wire logic        busy_req,
    input  wire logic [3:0]  done_dly,
    // Engine requests
    input  wire logic        op_start,
    input  wire logic [15:0] op_cmd,
    // Engine answers
    output logic             shared_busy,
    output logic             op_done,
    output int               starts,
    output logic [15:0]      last_cmd
);
    logic [3:0] cnt = 4'h0;

    initial begin
        shared_busy = 1'b1;
        op_done = 1'b0;
        starts = 0;
        last_cmd = 16'h0000;
    end

    // Counts each start cycle, so a stretched start pulse shows up
    always @(posedge clk) begin
        shared_busy <= busy_req;
        op_done <= (cnt == 4'h1);
        if (op_start) begin
            starts <= starts + 1;
            last_cmd <= op_cmd;
            cnt <= done_dly;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

// File: sim/test_nvm_manager_command_front_end.sv
`timescale 1ns/10ps
module test_nvm_manager_command_front_end
    import nmf_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         rst_b = 1'b0;
    logic         wr_en = 1'b0;
    logic         rd_en = 1'b0;
    logic         busy_req = 1'b1;
    logic         rd_d = 1'b0;
    logic [7:0]   addr = 8'h00;
    logic [31:0]  wr_data = 32'h0;
    logic [3:0]   done_dly = 4'h6;
    logic [31:0]  rd_data;
    logic         shared_busy;
    logic         op_done;
    logic         op_start;
    logic         lock_held;
    logic [15:0]  op_cmd;
    logic [15:0]  last_cmd;
    logic [7:0]   read_opcode;
    nmf_mgr_cfg_t mgr_cfg;
    nmf_dev_cfg_t dev_cfg;
    int           starts;
    int           error_cnt = 0;
    int           tests_run = 0;
    logic [31:0]  r;
    logic [31:0]  cap;
    logic [31:0]  exp_q[$];
    string        nam_q[$];
    logic [15:0]  ac [7] = '{CMD_READ, CMD_WRITE, CMD_ERASE_BLK,
        CMD_ERASE_ALL, CMD_QUERY_DEV, CMD_VALIDATE, CMD_ISSUE_OP};
    logic [31:0]  cr [4] = '{RATE_CEILING + 1, RATE_FLOOR - 1,
        RATE_CEILING, RATE_CEILING};
    logic [31:0]  cm [4] = '{32'h0103, 32'h0003, 32'h0102, 32'h0000};
    logic [3:0]   cx [4] = '{RES_INVALID, RES_INVALID, RES_INVALID, RES_OK};

    nmf_cmd_front DUT (.CORE_CLK(core_clk), .RST_B(rst_b), .ADDR(addr),
        .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
        .SHARED_BUSY(shared_busy), .OP_DONE(op_done), .OP_START(op_start),
        .OP_CMD(op_cmd), .LOCK_HELD(lock_held), .MGR_CFG(mgr_cfg),
        .DEV_CFG(dev_cfg), .READ_OPCODE(read_opcode));

    nmf_mem_model engine (.clk(core_clk), .busy_req(busy_req),
        .done_dly(done_dly), .op_start(op_start), .op_cmd(op_cmd),
        .shared_busy(shared_busy), .op_done(op_done), .starts(starts),
        .last_cmd(last_cmd));

    always #50 core_clk = ~core_clk;

    task automatic check(string n, logic [63:0] seen, logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", n, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e, string n);
        addr <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        exp_q.push_back(e);
        nam_q.push_back(n);
        @(posedge core_clk);
    endtask

    task automatic idle(int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask

    task automatic cmd(logic [15:0] c, logic a, logic [3:0] res);
        wr(REG_CMD, {16'h0000, c});
        rd(REG_RESULT, {23'h0, a, 4'h0, res}, "result");
    endtask

    // Read data stand only in the cycle after the read strobe
    always @(posedge core_clk) rd_d <= rd_en;
    always @(negedge core_clk) begin
        if (rd_d)
            check(nam_q.pop_front(), rd_data, exp_q.pop_front());
        else
            check("rd idle", rd_data, 32'h0);
    end

    initial begin
        #(5000 * 100);
        error_cnt++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'hCBDF8D0F));
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        idle(1);
        @(negedge core_clk);
        check("owner", lock_held, 1'b0);
        check("mgr", mgr_cfg, {RATE_FLOOR, 16'h0000});
        check("opcode", read_opcode, OPC_READ_STD);
        check("dev", dev_cfg, 64'h0);
        @(posedge core_clk);
        rd(REG_STATUS, 32'h0, "status");
        rd(8'hFC, 32'h0, "unmapped");
        cmd(CMD_MGR_CFG, 1'b0, RES_NOT_OWNER);
        cmd(CMD_DEV_CFG, 1'b0, RES_NOT_OWNER);
        foreach (ac[i]) cmd(ac[i], 1'b1, RES_NOT_OWNER);
        cmd(CMD_LOCK_REQ, 1'b1, RES_OK);
        cmd(CMD_LOCK_REQ, 1'b1, RES_PENDING);
        cmd(CMD_LOCK_QUERY, 1'b0, RES_PENDING);
        cmd(CMD_LOCK_FREE, 1'b0, RES_PENDING);
        rd(REG_STATUS, 32'h2, "status");
        busy_req <= 1'b0;
        idle(3);
        cmd(CMD_LOCK_QUERY, 1'b0, RES_OK);
        cmd(CMD_LOCK_REQ, 1'b1, RES_ALREADY);
        rd(REG_STATUS, 32'h1, "status");
        cmd(16'h850B, 1'b0, RES_UNKNOWN);
        foreach (ac[i]) begin
            cmd(ac[i], 1'b1, RES_OK);
            cmd(ac[i], 1'b1, RES_PENDING);
            cmd(CMD_OP_POLL, 1'b0, RES_PENDING);
            if (ac[i] == CMD_VALIDATE)
                cmd(CMD_VAL_POLL, 1'b0, RES_PENDING);
            rd(REG_STATUS, 32'h5, "status");
            idle(8);
            check("starts", starts, i + 1);
            check("op_cmd", last_cmd, ac[i]);
            cmd(CMD_OP_POLL, 1'b0, RES_OK);
            cmd(CMD_ISSUE_RSP, 1'b0, RES_OK);
        end
        done_dly <= 4'h1;
        cmd(CMD_ERASE_ALL, 1'b1, RES_OK);
        idle(4);
        cmd(CMD_OP_POLL, 1'b0, RES_OK);
        r = RATE_FLOOR + ($urandom % (RATE_CEILING - RATE_FLOOR + 1));
        wr(REG_MCFG_RATE, r);
        wr(REG_MCFG_MODE, 32'h0103);
        cmd(CMD_MGR_CFG, 1'b0, RES_OK);
        rd(REG_CMD, {16'h0000, CMD_MGR_CFG}, "cmd");
        rd(REG_MCFG_MODE, 32'h0000_0103, "mode");
        idle(1);
        @(negedge core_clk);
        check("mgr", mgr_cfg, {r, 16'h0301});
        check("opcode", read_opcode, OPC_READ_FAST);
        @(posedge core_clk);
        foreach (cr[i]) begin
            wr(REG_MCFG_RATE, cr[i]);
            wr(REG_MCFG_MODE, cm[i]);
            cmd(CMD_MGR_CFG, 1'b0, cx[i]);
        end
        rd(REG_MCFG_RATE, RATE_CEILING, "rate");
        for (int d = 0; d < 4; d++) begin
            cap = $urandom;
            wr(REG_DCFG_LO, {8'hFF, 8'h03, 8'h01, d[7:0]});
            wr(REG_DCFG_SIZE, cap);
            cmd(CMD_DEV_CFG, 1'b0, d < 3 ? RES_OK : RES_INVALID);
            rd(REG_DCFG_LO, {16'h0003, 8'h01, d < 3 ? d[7:0] : 8'h02},
                "dev");
            rd(REG_DCFG_SIZE, d < 3 ? cap : r, "size");
            if (d == 2)
                r = cap;
        end
        idle(1);
        @(negedge core_clk);
        check("opcode", read_opcode, OPC_READ_STD);
        check("dev", dev_cfg, {32'h02010300, r});
        @(posedge core_clk);
        cmd(CMD_LOCK_FREE, 1'b0, RES_OK);
        idle(1);
        @(negedge core_clk);
        check("owner", lock_held, 1'b0);
        @(posedge core_clk);
        cmd(CMD_READ, 1'b1, RES_NOT_OWNER);
        // Reset while the lock is held must drop it
        cmd(CMD_LOCK_REQ, 1'b1, RES_OK);
        idle(3);
        rd(REG_STATUS, 32'h1, "status");
        rst_b <= 1'b0;
        idle(2);
        rst_b <= 1'b1;
        idle(1);
        rd(REG_STATUS, 32'h0, "status");
        idle(3);
        end_of_test();
    end
endmodule
